// [design/energy_tamper_defines.svh]
// constants of the energy and tamper post-processing block
// How it works
// - out-of-range current and voltage samples clamp to 7fff or 8000
// - adapted current products saturate to 7fff or 8000
// - single-current setup keeps greater-channel and tamper flags at zero
// - mode 00 drops negative energy to zero; mode 01 sums its magnitude; flag set
// - mode 10 and reserved 11 sum signed, set flag, negative power factor
// - active energy result is signed in modes 10 and 11, never negative in 00 and 01
// - both currents under the minimum current skip the check and clear tamper
// - dual-current setup uses for energy the current flagged larger in the previous period
// - in dual-current setup, greater-channel flag is 0 when first >= second, else 1
// - tamper flag is evaluated once per 4096-sample period
// - tamper set when compared current reaches other current times ratio
// - dual-current setup picks the temperature channel by itself
// - parameters are written only through the mailbox words and then applied
`ifndef ENERGY_TAMPER_DEFINES_SVH
`define ENERGY_TAMPER_DEFINES_SVH

// apb byte offsets
`define OFF_MB_CMD 8'h00
`define OFF_MB_VALUE 8'h04
`define OFF_MBIN_CMD 8'h08
`define OFF_MBIN_VALUE 8'h0c
`define OFF_STATUS 8'h10
`define OFF_MASK 8'h14
`define OFF_FLAGS 8'h18
`define OFF_ENERGY 8'h1c
`define OFF_TOTAL 8'h20

// parameter pointers carried in the command word
`define PTR_CTRL 16'h0200
`define PTR_ADAPT1 16'h0210
`define PTR_ADAPT2 16'h0212
`define PTR_RATIO 16'h022e
`define PTR_TAMPER_MIN_CURRENT 16'h0230
`define MBIN_PARAM_SET 16'h0009

// control word fields
`define CTRL_DUAL 0
`define CTRL_NE_LO 3
`define CTRL_NE_HI 4

// status, mask and flag bits
`define ST_PERIOD 0
`define ST_TAMPER 1
`define ST_NEG 2
`define ST_PARAM 3
`define ST_W 4
`define FL_GT 0
`define FL_TAMP 1
`define FL_NEG 2
`define FL_PF_NEG 3
`define FL_TEMP_I2 4

// reset values
`define CTRL_RESET 16'h0000
`define ADAPT_RESET 16'h4000
`define RATIO_RESET 16'h4000
`define TAMPER_MIN_CURRENT_RESET 16'h0000

// arithmetic limits and period
`define SAT_POS 16'h7fff
`define SAT_NEG 16'h8000
`define ADAPT_SHIFT 14
`define RATIO_SHIFT 14
`define PERIOD_LAST 12'hfff

`endif

// [design/energy_tamper_pkg.sv]
// types of the energy and tamper post-processing block
package energy_tamper_pkg;

   typedef enum logic [1:0] {
      NEG_DROP = 2'b00,
      NEG_ABS = 2'b01,
      NEG_SIGNED = 2'b10,
      NEG_RSVD = 2'b11
   } neg_mode_type;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic irq;
      logic [15:0] ctrl;
      logic [15:0] adapt1;
      logic [15:0] adapt2;
      logic [15:0] ratio;
      logic [15:0] tamper_min_current;
      logic [15:0] mb_cmd;
      logic [15:0] mb_value;
      logic [15:0] mbin_cmd;
      logic [15:0] mbin_value;
      logic [3:0] status;
      logic [3:0] mask;
      logic signed [15:0] v_a;
      logic signed [15:0] i1_a;
      logic signed [15:0] i2_a;
      logic vld1;
      logic [11:0] cnt;
      logic signed [43:0] psum;
      logic [31:0] result;
      logic [31:0] total;
      logic gt;
      logic tamp;
      logic neg;
      logic pf_neg;
      logic temp_i2;
   } state_type;

endpackage

// [design/adapt_if.sv]
// carrier between the engine and its adaptation multipliers
`timescale 1ns/1ps
interface adapt_if;
   logic signed [15:0] sample;
   logic [15:0] factor;
   logic signed [15:0] product;
   modport src (output sample, output factor, input product);
   modport mul (input sample, input factor, output product);
endinterface // adapt_if

// [design/adapt_mul.sv]
// saturating multiply of a sample by its adaptation factor
`timescale 1ns/1ps
`include "energy_tamper_defines.svh"
module adapt_mul (
   adapt_if.mul a
);
   logic signed [32:0] full;
   logic signed [18:0] scaled;

   assign full = a.sample * $signed({1'b0, a.factor});
   assign scaled = full[32:`ADAPT_SHIFT];

   always_comb begin
      if (scaled > 19'sd32767) begin
         a.product = `SAT_POS;
      end else if (scaled < -19'sd32768) begin
         a.product = `SAT_NEG;
      end else begin
         a.product = scaled[15:0];
      end
   end
endmodule // adapt_mul

// [design/energy_tamper_check.sv]
// energy sign handling, channel choice and tamper check with apb access
//
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
`include "energy_tamper_defines.svh"
module energy_tamper_check
   import energy_tamper_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // samples from the converter path
   input wire logic sample_valid,
   input wire logic [23:0] v_sample,
   input wire logic [23:0] i1_sample,
   input wire logic [23:0] i2_sample,
   // rms values of the ending period
   input wire logic [31:0] i1_rms,
   input wire logic [31:0] i2_rms,
   // results and interrupt
   output logic irq,
   output logic second_current_greater_flag,
   output logic tamper_flag,
   output logic negative_energy_flag,
   output logic power_factor_negative,
   output logic temp_on_i2
);

   state_type r;
   state_type n;

   adapt_if a1 ();
   adapt_if a2 ();

   logic signed [15:0] v_c;
   logic signed [15:0] i1_c;
   logic signed [15:0] i2_c;
   logic setup;
   logic wr;
   logic hit;
   logic [31:0] rd;
   logic [3:0] set;
   logic [3:0] clr;
   logic period_end;
   logic dual;
   neg_mode_type mode;
   logic signed [15:0] isel;
   logic signed [31:0] prod;
   logic signed [43:0] psum_full;
   logic [31:0] e;
   logic neg_e;
   logic gt_new;
   logic below;
   logic [31:0] lhs;
   logic [31:0] oth;
   logic [47:0] oth_scaled;
   logic tamp_new;

   function automatic logic [15:0] sat16(input logic signed [23:0] x);
      if (x > 24'sd32767) begin
         return `SAT_POS;
      end else if (x < -24'sd32768) begin
         return `SAT_NEG;
      end else begin
         return x[15:0];
      end
   endfunction

   assign v_c = sat16(v_sample);
   assign i1_c = sat16(i1_sample);
   assign i2_c = sat16(i2_sample);

   assign a1.sample = i1_c;
   assign a1.factor = r.adapt1;
   assign a2.sample = i2_c;
   assign a2.factor = r.adapt2;

   adapt_mul mul1 (.a(a1));
   adapt_mul mul2 (.a(a2));

   assign setup = psel && !penable;
   assign wr = psel && penable && r.pready && pwrite;
   assign dual = r.ctrl[`CTRL_DUAL];
   assign mode = neg_mode_type'({r.ctrl[`CTRL_NE_HI], r.ctrl[`CTRL_NE_LO]});
   assign period_end = r.vld1 && (r.cnt == `PERIOD_LAST);

   // channel flagged larger feeds energy, the first one in single setup
   // selection follows the flag of the previous period
   assign isel = r.gt ? r.i2_a : r.i1_a;
   assign prod = r.v_a * isel;
   assign psum_full = r.psum + 44'(prod);
   assign e = psum_full[43:12];
   assign neg_e = psum_full[43];

   assign gt_new = i1_rms < i2_rms;
   assign below = (i1_rms < {r.tamper_min_current, 16'h0000}) && (i2_rms < {r.tamper_min_current, 16'h0000});
   assign lhs = gt_new ? i2_rms : i1_rms;
   assign oth = gt_new ? i1_rms : i2_rms;
   assign oth_scaled = oth * r.ratio;
   assign tamp_new = !below && ({2'b00, lhs, 14'h0000} >= oth_scaled);

   always_comb begin
      n = r;
      set = '0;
      clr = '0;
      hit = 1'b1;
      rd = '0;
      n.pready = 1'b0;
      n.pslverr = 1'b0;

      case (paddr)
         `OFF_MB_CMD: rd = {16'h0000, r.mb_cmd};
         `OFF_MB_VALUE: rd = {16'h0000, r.mb_value};
         `OFF_MBIN_CMD: rd = {16'h0000, r.mbin_cmd};
         `OFF_MBIN_VALUE: rd = {16'h0000, r.mbin_value};
         `OFF_STATUS: rd = {28'h0, r.status};
         `OFF_MASK: rd = {28'h0, r.mask};
         `OFF_FLAGS: rd = {27'h0, r.temp_i2, r.pf_neg, r.neg, r.tamp, r.gt};
         `OFF_ENERGY: rd = r.result;
         `OFF_TOTAL: rd = r.total;
         default: hit = 1'b0;
      endcase

      // answer in the first access cycle, data caught at setup
      if (setup) begin
         n.pready = 1'b1;
         n.prdata = hit ? rd : 32'h0000_0000;
         n.pslverr = !hit;
      end

      if (wr) begin
         case (paddr)
            `OFF_MB_VALUE: n.mb_value = pwdata[15:0];
            `OFF_MASK: n.mask = pwdata[3:0];
            `OFF_STATUS: clr = pwdata[3:0];
            `OFF_MB_CMD: begin
               // pointer in command, data in value
               n.mb_cmd = pwdata[15:0];
               case (pwdata[15:0])
                  `PTR_CTRL: n.ctrl = r.mb_value;
                  `PTR_ADAPT1: n.adapt1 = r.mb_value;
                  `PTR_ADAPT2: n.adapt2 = r.mb_value;
                  `PTR_RATIO: n.ratio = r.mb_value;
                  `PTR_TAMPER_MIN_CURRENT: n.tamper_min_current = r.mb_value;
                  default: n.ctrl = r.ctrl;
               endcase
               n.mbin_cmd = `MBIN_PARAM_SET;
               n.mbin_value = pwdata[15:0];
               set[`ST_PARAM] = 1'b1;
            end
            default: n.mask = r.mask;
         endcase
      end

      // sample stage: clamp and adapt
      n.vld1 = sample_valid;
      if (sample_valid) begin
         n.v_a = v_c;
         n.i1_a = a1.product;
         n.i2_a = a2.product;
      end

      // energy stage
      if (r.vld1) begin
         n.cnt = r.cnt + 12'h001;
         n.psum = psum_full;
      end

      if (period_end) begin
         n.psum = '0;
         set[`ST_PERIOD] = 1'b1;
         if (!dual) begin
            n.gt = 1'b0;
            n.tamp = 1'b0;
            n.temp_i2 = 1'b1;
         end else begin
            n.gt = gt_new;
            n.tamp = tamp_new;
            n.temp_i2 = !gt_new;
         end
         if (n.tamp && !r.tamp) begin
            set[`ST_TAMPER] = 1'b1;
         end
         n.neg = neg_e;
         n.pf_neg = 1'b0;
         if (!neg_e) begin
            n.result = e;
            n.total = r.total + e;
         end else begin
            set[`ST_NEG] = 1'b1;
            case (mode)
               NEG_DROP: n.result = 32'h0000_0000;
               NEG_ABS: begin
                  n.result = -e;
                  n.total = r.total - e;
               end
               NEG_SIGNED, NEG_RSVD: begin
                  n.result = e;
                  n.total = r.total + e;
                  n.pf_neg = 1'b1;
               end
               default: n.result = e;
            endcase
         end
      end

      // a new event beats a clear in the same cycle
      n.status = (r.status & ~clr) | set;
      n.irq = |(n.status & n.mask);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         r <= '0;
         r.ctrl <= `CTRL_RESET;
         r.adapt1 <= `ADAPT_RESET;
         r.adapt2 <= `ADAPT_RESET;
         r.ratio <= `RATIO_RESET;
         r.tamper_min_current <= `TAMPER_MIN_CURRENT_RESET;
         r.temp_i2 <= 1'b1;
      end else begin
         r <= n;
      end
   end

   assign prdata = r.prdata;
   assign pready = r.pready;
   assign pslverr = r.pslverr;
   assign irq = r.irq;
   assign second_current_greater_flag = r.gt;
   assign tamper_flag = r.tamp;
   assign negative_energy_flag = r.neg;
   assign power_factor_negative = r.pf_neg;
   assign temp_on_i2 = r.temp_i2;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   clamp_high_a: assert property (sample_valid && $signed(i1_sample) > 24'sd32767 |-> i1_c == `SAT_POS)
      else $error("current sample not clamped high");
   sat_product_a: assert property (sample_valid && i1_c == `SAT_POS && r.adapt1 >= 16'h8000
      |=> r.i1_a == `SAT_POS)
      else $error("adapted product not saturated");
   single_mode_zero_a: assert property (period_end && !dual
      |=> !second_current_greater_flag && !tamper_flag)
      else $error("single mode flags not zero");
   neg_drop_a: assert property (period_end && neg_e && mode == NEG_DROP
      |=> r.result == 32'h0 && negative_energy_flag && $stable(r.total))
      else $error("negative energy not dropped");
   neg_signed_a: assert property (period_end && neg_e && mode[1]
      |=> power_factor_negative && r.result[31])
      else $error("signed mode result wrong");
   tamper_gate_a: assert property (period_end && dual && below |=> !tamper_flag)
      else $error("tamper set below minimum current");
   greater_flag_a: assert property (period_end && dual
      |=> second_current_greater_flag == $past(i1_rms < i2_rms))
      else $error("greater-channel flag wrong");
   flag_hold_a: assert property (!period_end |=> $stable(tamper_flag) && $stable(second_current_greater_flag))
      else $error("flags changed inside a period");
   apb_ready_a: assert property (setup |=> pready ##1 !pready)
      else $error("apb answer timing wrong");
   irq_level_a: assert property (irq == |(r.status & r.mask))
      else $error("interrupt level wrong");
   clamp_low_a: assert property (sample_valid && $signed(i1_sample) < -24'sd32768 |-> i1_c == `SAT_NEG)
      else $error("current sample not clamped low");
   volt_clamp_a: assert property (sample_valid && $signed(v_sample) > 24'sd32767 |-> v_c == `SAT_POS)
      else $error("voltage sample not clamped high");
   neg_abs_a: assert property (period_end && neg_e && mode == NEG_ABS
      |=> negative_energy_flag && !power_factor_negative && !r.result[31])
      else $error("magnitude mode result wrong");
   period_status_a: assert property (period_end |=> r.status[`ST_PERIOD])
      else $error("period event not flagged");
   temp_channel_a: assert property (period_end && dual |=> temp_on_i2 == !second_current_greater_flag)
      else $error("temperature channel wrong");

   tamper_seen_c: cover property (period_end && dual && tamp_new);
   neg_seen_c: cover property (period_end && neg_e);
   param_set_c: cover property (wr && paddr == `OFF_MB_CMD);
   irq_seen_c: cover property (irq);
endmodule // energy_tamper_check

// [bench/host_model.sv]
// apb master model standing in for the host cpu
`timescale 1ns/1ps
`include "energy_tamper_defines.svh"
module host_model (
   // clock
   input wire logic clk,
   // apb master side
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   logic timed_out;

   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      timed_out = 1'b0;
   end

   // request held until pready is seen high; a stuck slave raises timed_out
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic er);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         timed_out = 1'b1;
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // value word first, pointer word applies it
   task automatic set_param(input logic [15:0] ptr, input logic [15:0] val);
      logic [31:0] rd;
      logic er;
      xfer(1'b1, `OFF_MB_VALUE, {16'h0, val}, rd, er);
      xfer(1'b1, `OFF_MB_CMD, {16'h0, ptr}, rd, er);
   endtask
endmodule // host_model

// [bench/energy_tamper_check_tb.sv]
// self-checking bench of the energy and tamper block
`timescale 1ns/1ps
`include "energy_tamper_defines.svh"
module energy_tamper_check_tb;
   typedef struct packed {
      logic [15:0] ctrl;
      logic [15:0] adapt;
      logic [23:0] v;
      logic [23:0] i1;
      logic [23:0] i2;
      logic [31:0] r1;
      logic [31:0] r2;
      logic [31:0] res;
      logic [4:0] fl;
   } row_type;
   logic clk, rst, psel, penable, pwrite, pready, pslverr, sample_valid, irq, er;
   logic gt, tf, nf, pf, t2;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, i1_rms, i2_rms, rd, tot;
   logic [23:0] v_sample, i1_sample, i2_sample;
   logic [4:0] fl;
   int errors;
   int samples_checked;
   // flags {temp_on_i2, pf_neg, neg, tamper, gt}; single rows carry big i2 rms to catch flag leaks
   row_type rows [12] = '{
      '{16'h0, 16'h4000, 24'h3e8, 24'hfffc18, 24'h0, 32'h1, 32'h100000, 32'h0, 5'h14},
      '{16'h8, 16'h4000, 24'h3e8, 24'hfffc18, 24'h0, 32'h1, 32'h100000, 32'hf4240, 5'h14},
      '{16'h10, 16'h4000, 24'h3e8, 24'hfffc18, 24'h0, 32'h1, 32'h100000, 32'hfff0bdc0, 5'h1c},
      '{16'h18, 16'h4000, 24'h3e8, 24'hfffc18, 24'h0, 32'h1, 32'h100000, 32'hfff0bdc0, 5'h1c},
      '{16'h10, 16'h4000, 24'h100000, 24'hfeee90, 24'h0, 32'h1, 32'h100000, 32'hc0008000, 5'h1c},
      '{16'h0, 16'hffff, 24'h3e8, 24'h4e20, 24'h0, 32'h1, 32'h100000, 32'h1f3fc18, 5'h10},
      '{16'h0, 16'hffff, 24'h3e8, 24'h010000, 24'h0, 32'h1, 32'h100000, 32'h1f3fc18, 5'h10},
      '{16'h10, 16'hffff, 24'h3e8, 24'hffb1e0, 24'h0, 32'h1, 32'h100000, 32'hfe0c0000, 5'h1c},
      '{16'h11, 16'h4000, 24'h3e8, 24'h3e8, 24'h7d0, 32'h100000, 32'h80000, 32'hf4240, 5'h12},
      '{16'h11, 16'h4000, 24'h3e8, 24'h3e8, 24'h7d0, 32'h80000, 32'hc0000, 32'hf4240, 5'h03},
      '{16'h11, 16'h4000, 24'h3e8, 24'h3e8, 24'h7d0, 32'h80000, 32'hbffff, 32'h1e8480, 5'h01},
      '{16'h11, 16'h2000, 24'h3e8, 24'h3e8, 24'h7d0, 32'h80000, 32'h80000, 32'hf4240, 5'h10}};

   assign fl = {t2, pf, nf, tf, gt};

   energy_tamper_check u_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sample_valid(sample_valid), .v_sample(v_sample), .i1_sample(i1_sample), .i2_sample(i2_sample),
      .i1_rms(i1_rms), .i2_rms(i2_rms), .irq(irq), .second_current_greater_flag(gt), .tamper_flag(tf),
      .negative_energy_flag(nf), .power_factor_negative(pf), .temp_on_i2(t2));

   host_model u_host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

   task automatic stop_test;
      if (errors == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %s exp %h got %h", nm, exp, got);
      end
   endtask

   task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
      u_host.xfer(1'b0, a, 32'h0, rd, er);
      chk(nm, exp, rd);
   endtask

   task automatic param(input logic [15:0] p, input logic [15:0] v);
      u_host.set_param(p, v);
      rd_chk("mbin_cmd", `OFF_MBIN_CMD, {16'h0, `MBIN_PARAM_SET});
      rd_chk("mbin_val", `OFF_MBIN_VALUE, {16'h0, p});
   endtask

   // one full period of 4096 samples, every cycle, then results
   task automatic period(input row_type r);
      param(`PTR_ADAPT1, r.adapt);
      param(`PTR_ADAPT2, r.adapt);
      param(`PTR_CTRL, r.ctrl);
      v_sample <= r.v;
      i1_sample <= r.i1;
      i2_sample <= r.i2;
      i1_rms <= r.r1;
      i2_rms <= r.r2;
      repeat (4096) begin
         @(posedge clk);
         sample_valid <= 1'b1;
      end
      @(posedge clk);
      sample_valid <= 1'b0;
      repeat (4) @(posedge clk);
      tot = tot + r.res;
      chk("flag_pins", {27'h0, r.fl}, {27'h0, fl});
      rd_chk("flags", `OFF_FLAGS, {27'h0, r.fl});
      rd_chk("energy", `OFF_ENERGY, r.res);
      rd_chk("total", `OFF_TOTAL, tot);
   endtask

   // hung bus ends the run as a failure
   always @(posedge clk) begin
      if (u_host.timed_out === 1'b1) begin
         errors++;
         stop_test();
      end
   end

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   initial begin
      rst = 1'b1;
      sample_valid = 1'b0;
      v_sample = 24'h0;
      i1_sample = 24'h0;
      i2_sample = 24'h0;
      i1_rms = 32'h0;
      i2_rms = 32'h0;
      errors = 0;
      samples_checked = 0;
      tot = 32'h0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      param(`PTR_RATIO, 16'h6000);
      foreach (rows[k]) begin
         period(rows[k]);
      end
      rd_chk("status", `OFF_STATUS, 32'hf);
      wr_mask: u_host.xfer(1'b1, `OFF_MASK, 32'h2, rd, er);
      repeat (2) @(posedge clk);
      chk("irq_on", 32'h1, {31'h0, irq});
      u_host.xfer(1'b1, `OFF_STATUS, 32'hf, rd, er);
      repeat (2) @(posedge clk);
      chk("irq_off", 32'h0, {31'h0, irq});
      rd_chk("status_clr", `OFF_STATUS, 32'h0);
      param(`PTR_TAMPER_MIN_CURRENT, 16'h20);
      period(row_type'{16'h11, 16'h4000, 24'h3e8, 24'h3e8, 24'h7d0, 32'h100000, 32'h80000,
         32'hf4240, 5'h10});
      u_host.xfer(1'b0, 8'h24, 32'h0, rd, er);
      chk("unmapped_err", 32'h1, {31'h0, er});
      chk("unmapped_data", 32'h0, rd);
      u_host.xfer(1'b1, `OFF_ENERGY, 32'h0, rd, er);
      rd_chk("ro_energy", `OFF_ENERGY, 32'hf4240);
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      chk("rst_pins", 32'h10, {26'h0, irq, fl});
      rst <= 1'b0;
      rd_chk("rst_total", `OFF_TOTAL, 32'h0);
      rd_chk("rst_mask", `OFF_MASK, 32'h0);
      rd_chk("rst_mbin", `OFF_MBIN_CMD, 32'h0);
      stop_test();
   end
endmodule // energy_tamper_check_tb
